/* logic/plpr_pkg.sv */
// Package: register map, field positions, reset values and timing for the loopback/power-down registers
package plpr_pkg;
	// Register addresses
	localparam logic [4:0] ADDR_LOOP = 5'h13;
	localparam logic [4:0] ADDR_ERRS = 5'h14;
	localparam logic [4:0] ADDR_SLEEP = 5'h15;
	// Loopback register fields
	localparam int LB_ALLDIG_POS = 12;
	localparam int LB_LDRV_POS = 10;
	localparam int LB_FAR_POS = 9;
	localparam int LB_QUIET_POS = 8;
	localparam int LB_CABLE_POS = 7;
	localparam int LB_MUTE_POS = 6;
	localparam int LB_LINK_POS = 0;
	localparam int LB_SPARE_HI_POS = 13;
	localparam logic [15:0] LOOP_RESET = 16'h1041;
	// Writable bits: [15:13] reserved r/w, 12,10,9,8,7,6,0
	localparam logic [15:0] LOOP_WMASK = 16'hf7c1;
	// Sleep register fields
	localparam int SL_EN_POS = 3;
	localparam int SL_PULSE_POS = 2;
	localparam int SL_FLAG_POS = 1;
	localparam int SL_SPARE_POS = 0;
	localparam logic [15:0] SLEEP_RESET = 16'h0000;
	localparam logic [15:0] ERRS_RESET = 16'h0000;
	// Timing, in ms; cycles at 100 MHz
	localparam int CLK_MHZ = 100;
	localparam int IDLE_MS = 1000;
	localparam int PULSE_MS = 1000;
	localparam int IDLE_CYC = IDLE_MS * CLK_MHZ * 1000;
	localparam int PULSE_CYC = PULSE_MS * CLK_MHZ * 1000;
	localparam int BURST_CYC = 16;

	typedef struct packed {
		logic all_digital_loop_select;
		logic line_driver_loop_select;
		logic far_end_loop_enable;
		logic mac_receive_quiet;
		logic cable_loop_enable;
		logic loop_transmit_mute;
		logic loop_link_good_force;
	} plpr_loop_s;

	typedef struct packed {
		logic idle_line_sleep_enable;
		logic sleep_pulse_send_enable;
	} plpr_sleep_s;
endpackage : plpr_pkg

/* logic/plpr_sleep_fsm.sv */
// Energy-detect power-down sequencer with periodic wake pulses
`timescale 1ns/10ps
module plpr_sleep_fsm #(
	parameter int IDLE_CYCLES = plpr_pkg::IDLE_CYC,
	parameter int PULSE_CYCLES = plpr_pkg::PULSE_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Control and line status
	input wire plpr_pkg::plpr_sleep_s cfg_i,
	input wire logic energy_i,
	// State
	output logic asleep_o,
	output logic pulse_o
);
	typedef enum logic [1:0] {
		ST_AWAKE = 2'b00,
		ST_SLEEP = 2'b01,
		ST_BURST = 2'b10
	} plpr_sl_e;

	plpr_sl_e st_q, st_d;
	logic [31:0] cnt_q, cnt_d;

	default clocking cb_fsm @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q + 32'h1;
		case (st_q)
			ST_AWAKE: begin
				if (energy_i || !cfg_i.idle_line_sleep_enable) begin
					cnt_d = 32'h0;
				end else if (cnt_q >= 32'(IDLE_CYCLES - 1)) begin
					st_d = ST_SLEEP;
					cnt_d = 32'h0;
				end
			end
			ST_SLEEP: begin
				if (energy_i || !cfg_i.idle_line_sleep_enable) begin
					st_d = ST_AWAKE;
					cnt_d = 32'h0;
				end else if (cfg_i.sleep_pulse_send_enable && cnt_q >= 32'(PULSE_CYCLES - 1)) begin
					st_d = ST_BURST;
					cnt_d = 32'h0;
				end
			end
			ST_BURST: begin
				if (energy_i || !cfg_i.idle_line_sleep_enable) begin
					st_d = ST_AWAKE;
					cnt_d = 32'h0;
				end else if (cnt_q >= 32'(plpr_pkg::BURST_CYC - 1)) begin
					st_d = ST_SLEEP;
					cnt_d = 32'h0;
				end
			end
			default: begin
				st_d = ST_AWAKE;
				cnt_d = 32'h0;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= ST_AWAKE;
			cnt_q <= 32'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end
	end

	// Wake bursts still count as power-down for the status flag
	assign asleep_o = (st_q != ST_AWAKE);
	assign pulse_o = (st_q == ST_BURST);

	// A burst may be cut short by line energy or by clearing the enable
	property p_burst_len;
		pulse_o && !energy_i && cfg_i.idle_line_sleep_enable && cnt_q < 32'(plpr_pkg::BURST_CYC - 1) |=> pulse_o;
	endproperty
	a_burst_len: assert property (p_burst_len) else $error("wake burst too short");
	property p_pulse_en;
		$rose(pulse_o) |-> $past(cfg_i.sleep_pulse_send_enable);
	endproperty
	a_pulse_en: assert property (p_pulse_en) else $error("wake burst without enable");
	property p_wake;
		asleep_o && (energy_i || !cfg_i.idle_line_sleep_enable) |=> !asleep_o;
	endproperty
	a_wake: assert property (p_wake) else $error("power-down not left");
endmodule : plpr_sleep_fsm

/* logic/plpr_regs.sv */
// Loopback control, frame-check error tally and energy power-down registers
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Digital loopback returns MAC transmit data
// - Line-driver select enters line loopback
// - Far-end enable echoes remote data back
// - Quiet bit blanks MAC receive during loopback
// - Cable loop stops echo cancelling own signal
// - Mute blanks line transmit in digital loopback
// - Force link good during MII loopback
// - Loopback register resets to 0x1041
// - Sixteen-bit frame checker error tally
// - Reading tally returns value then clears
// - Idle line with enable enters power-down
// - Sleep pulses sent periodically when enabled
// - Status bit shows power-down state
// - Sleep enables reset from strap pins
module plpr_regs #(
	parameter int IDLE_CYCLES = plpr_pkg::IDLE_CYC,
	parameter int PULSE_CYCLES = plpr_pkg::PULSE_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Management register port (decoded MDIO frames)
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	// Straps and core status
	input wire plpr_pkg::plpr_sleep_s strap_i,
	input wire logic loopback_bit_i,
	input wire logic link_up_i,
	input wire logic frame_err_i,
	input wire logic energy_i,
	// Loopback datapath steering
	output plpr_pkg::plpr_loop_s loop_cfg_o,
	output logic digital_loop_o,
	output logic line_driver_loop_o,
	output logic far_end_loop_o,
	output logic cable_loop_o,
	output logic mac_rx_block_o,
	output logic line_tx_block_o,
	output logic link_good_force_o,
	// Power-down
	output logic sleep_state_flag_o,
	output logic wake_pulse_o
);
	////////////////////////////////////////////////////////////////////////////////
	logic [15:0] loop_q, loop_d;
	logic [15:0] tally_q, tally_d;
	logic [1:0] sleep_q, sleep_d;
	logic spare_q, spare_d;
	logic strap_done_q, strap_done_d;
	logic [15:0] rdata_d;
	plpr_pkg::plpr_loop_s cfg;
	logic asleep, pulse, lb_active;
	logic dig_d, ld_d, far_d, cab_d, rxb_d, txb_d, lnk_d;

	default clocking cb_regs @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
		return a == r;
	endfunction : hit

	always_comb begin
		cfg.all_digital_loop_select = loop_q[plpr_pkg::LB_ALLDIG_POS];
		cfg.line_driver_loop_select = loop_q[plpr_pkg::LB_LDRV_POS];
		cfg.far_end_loop_enable = loop_q[plpr_pkg::LB_FAR_POS];
		cfg.mac_receive_quiet = loop_q[plpr_pkg::LB_QUIET_POS];
		cfg.cable_loop_enable = loop_q[plpr_pkg::LB_CABLE_POS];
		cfg.loop_transmit_mute = loop_q[plpr_pkg::LB_MUTE_POS];
		cfg.loop_link_good_force = loop_q[plpr_pkg::LB_LINK_POS];
	end

	plpr_sleep_fsm #(
		.IDLE_CYCLES(IDLE_CYCLES),
		.PULSE_CYCLES(PULSE_CYCLES)
	) u_sleep (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.cfg_i({sleep_q[1], sleep_q[0]}),
		.energy_i(energy_i),
		.asleep_o(asleep),
		.pulse_o(pulse)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register next values
	always_comb begin
		loop_d = loop_q;
		tally_d = tally_q;
		sleep_d = sleep_q;
		spare_d = spare_q;
		strap_done_d = 1'b1;
		// Straps sampled on the first clock after reset release, not inside the reset branch
		if (!strap_done_q) begin
			sleep_d = {strap_i.idle_line_sleep_enable, strap_i.sleep_pulse_send_enable};
		end
		if (reg_wr_i && hit(reg_addr_i, plpr_pkg::ADDR_LOOP)) begin
			loop_d = reg_wdata_i & plpr_pkg::LOOP_WMASK;
		end
		if (reg_wr_i && hit(reg_addr_i, plpr_pkg::ADDR_SLEEP)) begin
			sleep_d = {reg_wdata_i[plpr_pkg::SL_EN_POS], reg_wdata_i[plpr_pkg::SL_PULSE_POS]};
			spare_d = reg_wdata_i[plpr_pkg::SL_SPARE_POS];
		end
		// Clear on read; an error in the same cycle survives as a count of one
		if (reg_rd_i && hit(reg_addr_i, plpr_pkg::ADDR_ERRS)) begin
			tally_d = {15'h0, frame_err_i};
		end else if (frame_err_i && tally_q != 16'hffff) begin
			tally_d = tally_q + 16'h1;
		end
	end

	always_comb begin
		rdata_d = 16'h0;
		if (hit(reg_addr_i, plpr_pkg::ADDR_LOOP)) begin
			rdata_d = loop_q;
		end else if (hit(reg_addr_i, plpr_pkg::ADDR_ERRS)) begin
			rdata_d = tally_q;
		end else if (hit(reg_addr_i, plpr_pkg::ADDR_SLEEP)) begin
			rdata_d[plpr_pkg::SL_EN_POS] = sleep_q[1];
			rdata_d[plpr_pkg::SL_PULSE_POS] = sleep_q[0];
			rdata_d[plpr_pkg::SL_FLAG_POS] = asleep;
			rdata_d[plpr_pkg::SL_SPARE_POS] = spare_q;
		end
		if (!reg_rd_i) begin
			rdata_d = reg_rdata_o;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Loopback steering
	always_comb begin
		lb_active = loopback_bit_i || (cfg.far_end_loop_enable && link_up_i) || cfg.cable_loop_enable;
		dig_d = cfg.all_digital_loop_select && loopback_bit_i;
		ld_d = cfg.line_driver_loop_select && loopback_bit_i;
		far_d = cfg.far_end_loop_enable && link_up_i;
		// Cable loop only when software left the loopback bit clear
		cab_d = cfg.cable_loop_enable && !loopback_bit_i;
		rxb_d = cfg.mac_receive_quiet && lb_active;
		txb_d = cfg.loop_transmit_mute && dig_d;
		lnk_d = cfg.loop_link_good_force && loopback_bit_i;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			loop_q <= plpr_pkg::LOOP_RESET;
			tally_q <= plpr_pkg::ERRS_RESET;
			sleep_q <= plpr_pkg::SLEEP_RESET[plpr_pkg::SL_PULSE_POS +: 2];
			spare_q <= 1'b0;
			strap_done_q <= 1'b0;
			reg_rdata_o <= 16'h0;
			loop_cfg_o <= '0;
			digital_loop_o <= 1'b0;
			line_driver_loop_o <= 1'b0;
			far_end_loop_o <= 1'b0;
			cable_loop_o <= 1'b0;
			mac_rx_block_o <= 1'b0;
			line_tx_block_o <= 1'b0;
			link_good_force_o <= 1'b0;
			sleep_state_flag_o <= 1'b0;
			wake_pulse_o <= 1'b0;
		end else begin
			loop_q <= loop_d;
			tally_q <= tally_d;
			sleep_q <= sleep_d;
			spare_q <= spare_d;
			strap_done_q <= strap_done_d;
			reg_rdata_o <= rdata_d;
			loop_cfg_o <= cfg;
			digital_loop_o <= dig_d;
			line_driver_loop_o <= ld_d;
			far_end_loop_o <= far_d;
			cable_loop_o <= cab_d;
			mac_rx_block_o <= rxb_d;
			line_tx_block_o <= txb_d;
			link_good_force_o <= lnk_d;
			sleep_state_flag_o <= asleep;
			wake_pulse_o <= pulse;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_reset_val;
		$rose(strap_done_q) |-> $past(loop_q) == plpr_pkg::LOOP_RESET || $past(reg_wr_i);
	endproperty
	a_reset_val: assert property (p_reset_val) else $error("loopback reset value wrong");
	property p_strap;
		$rose(strap_done_q) && !$past(reg_wr_i) |-> sleep_q == $past(strap_i);
	endproperty
	a_strap: assert property (p_strap) else $error("sleep enables not taken from straps");
	property p_wmask;
		reg_wr_i && reg_addr_i == plpr_pkg::ADDR_LOOP |=> loop_q == ($past(reg_wdata_i) & plpr_pkg::LOOP_WMASK);
	endproperty
	a_wmask: assert property (p_wmask) else $error("loopback write not stored");
	property p_digital;
		loopback_bit_i && loop_q[plpr_pkg::LB_ALLDIG_POS] |=> digital_loop_o;
	endproperty
	a_digital: assert property (p_digital) else $error("digital loopback not entered");
	property p_dig_cause;
		digital_loop_o |-> $past(loop_q[plpr_pkg::LB_ALLDIG_POS] && loopback_bit_i);
	endproperty
	a_dig_cause: assert property (p_dig_cause) else $error("digital loopback without cause");
	property p_linedrv;
		loopback_bit_i && loop_q[plpr_pkg::LB_LDRV_POS] |=> line_driver_loop_o;
	endproperty
	a_linedrv: assert property (p_linedrv) else $error("line driver loopback not entered");
	property p_ldrv_cause;
		line_driver_loop_o |-> $past(loop_q[plpr_pkg::LB_LDRV_POS] && loopback_bit_i);
	endproperty
	a_ldrv_cause: assert property (p_ldrv_cause) else $error("line driver loopback without cause");
	property p_far;
		link_up_i && loop_q[plpr_pkg::LB_FAR_POS] |=> far_end_loop_o;
	endproperty
	a_far: assert property (p_far) else $error("far-end loopback not entered");
	property p_far_cause;
		far_end_loop_o |-> $past(loop_q[plpr_pkg::LB_FAR_POS] && link_up_i);
	endproperty
	a_far_cause: assert property (p_far_cause) else $error("far-end loopback without cause");
	property p_quiet;
		loopback_bit_i && loop_q[plpr_pkg::LB_QUIET_POS] |=> mac_rx_block_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("MAC receive not blocked");
	property p_quiet_cause;
		mac_rx_block_o |-> $past(loop_q[plpr_pkg::LB_QUIET_POS]);
	endproperty
	a_quiet_cause: assert property (p_quiet_cause) else $error("MAC receive blocked without cause");
	property p_cable;
		cable_loop_o |-> $past(loop_q[plpr_pkg::LB_CABLE_POS] && !loopback_bit_i);
	endproperty
	a_cable: assert property (p_cable) else $error("cable loop without cause");
	property p_cable_on;
		loop_q[plpr_pkg::LB_CABLE_POS] && !loopback_bit_i |=> cable_loop_o;
	endproperty
	a_cable_on: assert property (p_cable_on) else $error("cable loop not entered");
	property p_mute;
		line_tx_block_o |-> $past(loop_q[plpr_pkg::LB_MUTE_POS] && loop_q[plpr_pkg::LB_ALLDIG_POS] && loopback_bit_i);
	endproperty
	a_mute: assert property (p_mute) else $error("transmit muted without cause");
	property p_mute_on;
		loopback_bit_i && loop_q[plpr_pkg::LB_ALLDIG_POS] && loop_q[plpr_pkg::LB_MUTE_POS] |=> line_tx_block_o;
	endproperty
	a_mute_on: assert property (p_mute_on) else $error("transmit not muted");
	property p_link;
		loopback_bit_i && loop_q[plpr_pkg::LB_LINK_POS] |=> link_good_force_o;
	endproperty
	a_link: assert property (p_link) else $error("link good not forced");
	property p_link_cause;
		link_good_force_o |-> $past(loop_q[plpr_pkg::LB_LINK_POS] && loopback_bit_i);
	endproperty
	a_link_cause: assert property (p_link_cause) else $error("link good forced without cause");
	property p_clear;
		reg_rd_i && reg_addr_i == plpr_pkg::ADDR_ERRS |=> reg_rdata_o == $past(tally_q) && tally_q == {15'h0, $past(frame_err_i)};
	endproperty
	a_clear: assert property (p_clear) else $error("tally not returned and cleared");
	property p_count;
		frame_err_i && !reg_rd_i && tally_q < 16'hffff |=> tally_q == $past(tally_q) + 16'h1;
	endproperty
	a_count: assert property (p_count) else $error("tally did not count");
	property p_errs_ro;
		reg_wr_i && reg_addr_i == plpr_pkg::ADDR_ERRS && !reg_rd_i && !frame_err_i |=> tally_q == $past(tally_q);
	endproperty
	a_errs_ro: assert property (p_errs_ro) else $error("tally changed by a write");
	// The state machine sees the enable one cycle late, and the flag is one more flop behind
	property p_flag;
		sleep_state_flag_o |-> $past(sleep_q[1], 2);
	endproperty
	a_flag: assert property (p_flag) else $error("sleep without enable");
	property p_sleep_rd;
		reg_rd_i && reg_addr_i == plpr_pkg::ADDR_SLEEP |=> reg_rdata_o[plpr_pkg::SL_FLAG_POS] == $past(asleep);
	endproperty
	a_sleep_rd: assert property (p_sleep_rd) else $error("power-down status not read back");

	c_digital: cover property (@(posedge clk_i) disable iff (!resetn_i) digital_loop_o && line_tx_block_o);
	c_clear: cover property (@(posedge clk_i) disable iff (!resetn_i) reg_rd_i && reg_addr_i == 5'h14 && tally_q > 16'h1);
	c_sleep: cover property (@(posedge clk_i) disable iff (!resetn_i) wake_pulse_o);
endmodule : plpr_regs

/* tb/plpr_mgmt_model.sv */
// Station management model issuing decoded register frames
`timescale 1ns/10ps
module plpr_mgmt_model (
	// Clock
	input wire logic clk_i,
	// Register port
	output logic reg_rd_o,
	output logic reg_wr_o,
	output logic [4:0] reg_addr_o,
	output logic [15:0] reg_wdata_o,
	input wire logic [15:0] reg_rdata_i
);
	initial begin
		reg_rd_o = 1'b0;
		reg_wr_o = 1'b0;
		reg_addr_o = 5'h00;
		reg_wdata_o = 16'h0000;
	end

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk_i);
		reg_wr_o = 1'b1;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(negedge clk_i);
		reg_wr_o = 1'b0;
		// Released data must not keep its last value
		reg_wdata_o = ~d;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(negedge clk_i);
		reg_rd_o = 1'b1;
		reg_addr_o = a;
		@(negedge clk_i);
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rdata_i;
	endtask : rd
endmodule : plpr_mgmt_model

/* tb/tb.sv */
// Self-checking bench for the loopback and power-down registers
`timescale 1ns/10ps
module tb;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic reg_rd_i;
	logic reg_wr_i;
	logic [4:0] reg_addr_i;
	logic [15:0] reg_wdata_i;
	logic [15:0] reg_rdata_o;
	logic [15:0] rd;
	logic seen;
	plpr_pkg::plpr_sleep_s strap_i = 2'b11;
	logic loopback_bit_i = 1'b0;
	logic link_up_i = 1'b0;
	logic frame_err_i = 1'b0;
	logic energy_i = 1'b1;
	plpr_pkg::plpr_loop_s loop_cfg_o;
	logic digital_loop_o, line_driver_loop_o, far_end_loop_o, cable_loop_o;
	logic mac_rx_block_o, line_tx_block_o, link_good_force_o;
	logic sleep_state_flag_o, wake_pulse_o;
	int err_count = 0;
	int n_compared = 0;
	int i;

	always #5 clk_i = ~clk_i;

	// Short idle and pulse intervals keep the run brief
	plpr_regs #(.IDLE_CYCLES(20), .PULSE_CYCLES(50)) dut (.clk_i, .resetn_i, .reg_rd_i, .reg_wr_i,
		.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .strap_i, .loopback_bit_i, .link_up_i, .frame_err_i,
		.energy_i, .loop_cfg_o, .digital_loop_o, .line_driver_loop_o, .far_end_loop_o, .cable_loop_o,
		.mac_rx_block_o, .line_tx_block_o, .link_good_force_o, .sleep_state_flag_o, .wake_pulse_o);

	plpr_mgmt_model mgmt (.clk_i, .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));

	////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	function automatic logic [15:0] steer();
		return {9'h000, digital_loop_o, line_driver_loop_o, far_end_loop_o, cable_loop_o,
			mac_rx_block_o, line_tx_block_o, link_good_force_o};
	endfunction : steer

	////////////////////////////////////////
	task automatic t_reset();
		mgmt.rd(plpr_pkg::ADDR_LOOP, rd);
		chk(rd, 16'h1041);
		mgmt.rd(plpr_pkg::ADDR_ERRS, rd);
		chk(rd, 16'h0000);
		mgmt.rd(plpr_pkg::ADDR_SLEEP, rd);
		chk(rd, 16'h000c);
		$display("test reset done");
	endtask : t_reset

	task automatic t_loop();
		loopback_bit_i = 1'b1;
		link_up_i = 1'b1;
		// Loopback bit set with the cable loop enable (bit 7) written clear
		mgmt.wr(plpr_pkg::ADDR_LOOP, 16'hff7f);
		mgmt.rd(plpr_pkg::ADDR_LOOP, rd);
		chk(rd, 16'hf741);
		chk({9'h000, loop_cfg_o}, 16'h007b);
		chk(steer(), 16'h0077);
		loopback_bit_i = 1'b0;
		mgmt.wr(plpr_pkg::ADDR_LOOP, 16'hffff);
		mgmt.rd(plpr_pkg::ADDR_LOOP, rd);
		chk(rd, 16'hf7c1);
		chk({9'h000, loop_cfg_o}, 16'h007f);
		chk(steer(), 16'h001c);
		$display("test loop done");
	endtask : t_loop

	task automatic t_tally();
		repeat (3) begin
			@(negedge clk_i);
			frame_err_i = 1'b1;
			@(negedge clk_i);
			frame_err_i = 1'b0;
		end
		mgmt.wr(plpr_pkg::ADDR_ERRS, 16'h00ff);
		mgmt.rd(plpr_pkg::ADDR_ERRS, rd);
		chk(rd, 16'h0003);
		mgmt.rd(plpr_pkg::ADDR_ERRS, rd);
		chk(rd, 16'h0000);
		// An error in the read cycle survives the clear
		fork
			mgmt.rd(plpr_pkg::ADDR_ERRS, rd);
			begin
				@(negedge clk_i);
				frame_err_i = 1'b1;
				@(negedge clk_i);
				frame_err_i = 1'b0;
			end
		join
		chk(rd, 16'h0000);
		mgmt.rd(plpr_pkg::ADDR_ERRS, rd);
		chk(rd, 16'h0001);
		$display("test tally done");
	endtask : t_tally

	task automatic t_sleep();
		energy_i = 1'b0;
		mgmt.wr(plpr_pkg::ADDR_SLEEP, 16'hfffc);
		repeat (8) @(negedge clk_i);
		chk(16'(sleep_state_flag_o), 16'h0000);
		for (i = 0; i < 100 && sleep_state_flag_o !== 1'b1; i++) @(negedge clk_i);
		chk(16'(sleep_state_flag_o), 16'h0001);
		mgmt.rd(plpr_pkg::ADDR_SLEEP, rd);
		chk(rd, 16'h000e);
		for (i = 0; i < 200 && wake_pulse_o !== 1'b1; i++) @(negedge clk_i);
		chk(16'(wake_pulse_o), 16'h0001);
		energy_i = 1'b1;
		repeat (30) @(negedge clk_i);
		chk(16'(sleep_state_flag_o), 16'h0000);
		mgmt.rd(5'h1f, rd);
		chk(rd, 16'h0000);
		// Power-down without wake pulses, left by clearing the enable
		mgmt.wr(plpr_pkg::ADDR_SLEEP, 16'h0008);
		energy_i = 1'b0;
		for (i = 0; i < 100 && sleep_state_flag_o !== 1'b1; i++) @(negedge clk_i);
		chk(16'(sleep_state_flag_o), 16'h0001);
		seen = 1'b0;
		repeat (80) begin
			@(negedge clk_i);
			seen = seen | wake_pulse_o;
		end
		chk(16'(seen), 16'h0000);
		mgmt.wr(plpr_pkg::ADDR_SLEEP, 16'h0000);
		mgmt.rd(plpr_pkg::ADDR_SLEEP, rd);
		chk(rd, 16'h0000);
		chk(16'(sleep_state_flag_o), 16'h0000);
		energy_i = 1'b1;
		$display("test sleep done");
	endtask : t_sleep

	initial begin
		repeat (6) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (2) @(negedge clk_i);
		t_reset();
		t_loop();
		t_tally();
		t_sleep();
		report_and_stop();
	end

	// Whole run is under a thousand cycles
	initial begin
		#100000;
		err_count++;
		report_and_stop();
	end
endmodule : tb
